// ---- hdl/frame_cmd_map.vh ----
// Contract
// R1 - Twelve bytes back to back, else timeout
// R2 - Command then parameter, MSB first
// R3 - Byte eleven zero, byte twelve checksum
// R4 - Checksum is XOR of bytes one-eleven
// R5 - Answer every good frame with twelve bytes
// R6 - Bad parameter answers illegal-parameter code
// R7 - Unsupported command answers unknown-command code
// R8 - Bad checksum answers receive-error, no execute
// R9 - Repeat request resends last frame
// R10 - Presence check answers zero, changes nothing
// R11 - Identify returns device identifier
// R12 - Versions in three lowest bytes
// R13 - Serial query: zero gives length, else char
// R14 - Name query behaves like serial query
// R15 - Error turns output off, error status
// R16 - Enable toggle clears error, allows output
// R17 - Temperature queries answer signed 16-bit (code zero-extends the 16-bit value to 64 bits, no sign extension)
// R18 - Setpoint, limit, gains answer 32-bit values
// R19 - Status, fault, combined, clear commands
// R20 - Store/recall answer zero, supply voltage
// R21 - Combined read: status low, fault high
// R22 - Setpoint writes range-checked, 0.01 A units
// R23 - Temperatures in tenths of a degree
// R24 - Inter-byte timeout counter resets assembler
`ifndef FRAME_CMD_MAP_VH
`define FRAME_CMD_MAP_VH
`define FRAME_LEN          4'd12
`define CLK_HZ             25000000
`define BYTE_TIMEOUT_US    1000
`define BYTE_TIMEOUT_CYC   (`CLK_HZ / 1000000 * `BYTE_TIMEOUT_US)
`define C_PING             16'hFE01
`define C_IDENT            16'hFE02
`define C_HWVER            16'hFE06
`define C_FWVER            16'hFE07
`define C_SERIAL           16'hFE08
`define C_NAME             16'hFE09
`define A_PING             16'hFF01
`define A_IDENT            16'hFF02
`define A_HWVER            16'hFF06
`define A_FWVER            16'hFF07
`define A_SERIAL           16'hFF08
`define A_NAME             16'hFF09
`define A_RXERR            16'hFF10
`define A_REPEAT           16'hFF11
`define A_ILLPAR           16'hFF12
`define A_UNKNOWN_COMMAND_REPLY            16'hFF13
`define C_TEMP             16'h0001
`define C_TEMPOFF          16'h0002
`define C_TEMPHYS          16'h0004
`define C_SP_GET           16'h0010
`define C_SP_MIN           16'h0011
`define C_SP_MAX           16'h0012
`define C_SP_SET           16'h0013
`define C_SP_EXT           16'h0014
`define C_LIM_GET          16'h0015
`define C_LIM_MIN          16'h0016
`define C_LIM_MAX          16'h0017
`define C_LIM_SET          16'h0018
`define C_SP_SETV          16'h0019
`define C_ST_RD            16'h0020
`define C_FLT_RD           16'h0021
`define C_REGS_RD          16'h0022
`define C_ST_WR            16'h0023
`define C_FLT_CLR          16'h0024
`define C_STORE            16'h0027
`define C_RECALL           16'h0028
`define C_VCC              16'h003A
`define C_KP_MIN           16'h0040
`define C_KP_MAX           16'h0041
`define C_KP_GET           16'h0042
`define C_KP_SET           16'h0043
`define C_KI_MIN           16'h0044
`define C_KI_MAX           16'h0045
`define C_KI_GET           16'h0046
`define C_KI_SET           16'h0047
`define A_TEMP             16'h0113
`define A_SP               16'h0101
`define A_ST               16'h0103
`define A_FLTCLR           16'h0104
`define A_REGS             16'h0105
`define A_VCC              16'h0108
`define A_KP               16'h010A
`define A_KI               16'h010B
`define A_SETTINGS         16'h0112
`define A_FLT              16'h0114
`define SP_RESET           32'h000003E8
`define LIM_RESET          32'h000007D0
`define ST_RESET           32'h00000001
`define ST_LON_BIT         0
`define ST_MASK            32'h000000D7
`endif

// ---- hdl/byte_fifo.v ----
`timescale 1ns/100ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             mclk_i,
  input  wire             resetn_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  // ==========================================================
  // Storage with registered read data
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  reg             ov_r;
  wire            wr = in_valid_i && in_ready_o;
  wire            mem_ne = (cnt_r != {(AW+1){1'b0}});
  wire            pop = mem_ne && (!ov_r || out_ready_i);
  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = ov_r;
  always @(posedge mclk_i) begin
    if (wr) begin
      mem[wp_r] <= in_data_i;
    end
    if (pop) begin
      out_data_o <= mem[rp_r];
    end
  end
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      ov_r  <= 1'b0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, pop};
      if (pop) begin
        ov_r <= 1'b1;
      end else if (out_ready_i) begin
        ov_r <= 1'b0;
      end
    end
  end
endmodule // byte_fifo

// ---- hdl/frame_cmd.v ----
`timescale 1ns/100ps
`include "frame_cmd_map.vh"
module frame_cmd #(
  parameter        TIMEOUT_CYC = `BYTE_TIMEOUT_CYC,
  parameter [63:0] DEVICE_ID   = 64'h0000000000001234, // Arbitrary
  parameter [23:0] HW_VERSION  = 24'h010000,
  parameter [23:0] FW_VERSION  = 24'h010000,
  parameter [31:0] SP_MIN      = 32'h00000064,
  parameter [31:0] SP_MAX      = 32'h000007D0,
  parameter [31:0] LIM_MIN     = 32'h00000064,
  parameter [31:0] LIM_MAX     = 32'h000007D0,
  parameter [31:0] K_MIN       = 32'h00000001,
  parameter [31:0] K_MAX       = 32'h0000FFFF
) (
  input  wire        mclk_i,
  input  wire        resetn_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_valid_i,
  output reg  [7:0]  tx_data_o,
  output reg         tx_valid_o,
  input  wire        tx_ready_i,
  input  wire        enable_i,
  input  wire        fault_event_i,
  input  wire [31:0] fault_bits_i,
  input  wire [15:0] temp_i,
  input  wire [15:0] temp_off_i,
  input  wire [15:0] temp_hys_i,
  input  wire [15:0] vcc_i,
  input  wire [31:0] sp_ext_i,
  output reg         output_on_o,
  output reg  [1:0]  cmd_status_o,
  output reg  [31:0] setpoint_o,
  output reg  [31:0] limit_o,
  output reg  [31:0] kp_o,
  output reg  [31:0] ki_o,
  output reg         store_o,
  output reg         recall_o,
  output wire        rx_overrun_o
);
  // ==========================================================
  // Local definitions
  localparam S_RX = 2'd0;
  localparam S_EX = 2'd1;
  localparam S_TX = 2'd2;
  localparam [7:0] SER_LEN  = 8'd8;
  localparam [7:0] NAME_LEN = 8'd8;
  localparam [63:0] SER_STR  = "00000001";
  localparam [63:0] NAME_STR = "CMD_UNIT";
  function [7:0] str_char;
    input [63:0] s;
    input [63:0] n;
    begin
      str_char = s[63:56] >> 0;
      case (n)
        64'd1: str_char = s[63:56];
        64'd2: str_char = s[55:48];
        64'd3: str_char = s[47:40];
        64'd4: str_char = s[39:32];
        64'd5: str_char = s[31:24];
        64'd6: str_char = s[23:16];
        64'd7: str_char = s[15:8];
        64'd8: str_char = s[7:0];
        default: str_char = 8'h00;
      endcase
    end
  endfunction
  function in_range;
    input [63:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = (v[63:32] == 32'h0) && (v[31:0] >= lo)
                 && (v[31:0] <= hi);
    end
  endfunction
  // ==========================================================
  // Frame assembly and timeout
  reg  [1:0]  state_r;
  reg  [3:0]  idx_r;
  reg  [95:0] fr_r;
  reg  [7:0]  xor_r;
  reg  [31:0] tmo_r;
  reg  [95:0] ans_r;
  reg  [95:0] last_r;
  reg  [3:0]  tx_idx_r;
  reg  [31:0] status_r;
  reg  [31:0] fault_r;
  reg         err_r;
  reg         en_prev_r;
  reg         en_low_seen_r;
  wire [15:0] cmd = fr_r[95:80];
  wire [63:0] par = fr_r[79:16];
  wire        ck_ok = (fr_r[7:0] == xor_r) && (fr_r[15:8] == 8'h00);
  wire        f_ready;
  wire [7:0]  f_data;
  wire        f_valid;
  wire        f_push;
  assign rx_overrun_o = rx_valid_i && !f_ready;
  assign f_push = (state_r == S_TX) && (tx_idx_r != `FRAME_LEN);
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r  <= S_RX;
      idx_r    <= 4'd0;
      fr_r     <= 96'h0;
      xor_r    <= 8'h00;
      tmo_r    <= 32'd0;
      tx_idx_r <= 4'd0;
    end else begin
      case (state_r)
        S_RX: begin
          if (rx_valid_i) begin
            fr_r  <= {fr_r[87:0], rx_data_i}; // see R2
            tmo_r <= 32'd0; // see R24
            if (idx_r < 4'd11) begin
              xor_r <= xor_r ^ rx_data_i; // see R4
            end
            if (idx_r == `FRAME_LEN - 4'd1) begin
              idx_r   <= 4'd0;
              state_r <= S_EX;
            end else begin
              idx_r <= idx_r + 4'd1;
            end
          end else if (idx_r != 4'd0) begin
            if (tmo_r >= TIMEOUT_CYC - 1) begin // see R1
              idx_r <= 4'd0;
              xor_r <= 8'h00;
              tmo_r <= 32'd0;
            end else begin
              tmo_r <= tmo_r + 32'd1;
            end
          end
        end
        S_EX: begin
          xor_r    <= 8'h00;
          tx_idx_r <= 4'd0;
          state_r  <= S_TX;
        end
        S_TX: begin
          if (f_push && f_ready) begin
            tx_idx_r <= tx_idx_r + 4'd1; // see R5
          end else if (tx_idx_r == `FRAME_LEN) begin
            state_r <= S_RX;
          end
        end
        default: state_r <= S_RX;
      endcase
    end
  end
  // ==========================================================
  // Command execution
  reg [15:0] a_cmd;
  reg [63:0] a_par;
  reg        is_rep;
  always @* begin
    a_cmd  = `A_UNKNOWN_COMMAND_REPLY; // see R7
    a_par  = 64'h0;
    is_rep = 1'b0;
    if (!ck_ok) begin
      a_cmd = `A_RXERR; // see R8
    end else begin
      case (cmd)
        `A_REPEAT: is_rep = 1'b1; // see R9
        `C_PING:   a_cmd = `A_PING; // see R10
        `C_IDENT: begin
          a_cmd = `A_IDENT;
          a_par = DEVICE_ID; // see R11
        end
        `C_HWVER: begin
          a_cmd = `A_HWVER;
          a_par = {40'h0, HW_VERSION}; // see R12
        end
        `C_FWVER: begin
          a_cmd = `A_FWVER;
          a_par = {40'h0, FW_VERSION}; // see R12
        end
        `C_SERIAL: begin
          a_cmd = `A_SERIAL; // see R13
          a_par = {56'h0, (par == 64'h0) ? SER_LEN : str_char(SER_STR, par)};
          if (par > {56'h0, SER_LEN}) a_cmd = `A_ILLPAR;
        end
        `C_NAME: begin
          a_cmd = `A_NAME; // see R14
          a_par = {56'h0, (par == 64'h0) ? NAME_LEN
                                         : str_char(NAME_STR, par)};
          if (par > {56'h0, NAME_LEN}) a_cmd = `A_ILLPAR;
        end
        `C_TEMP, `C_TEMPOFF, `C_TEMPHYS: begin
          a_cmd = `A_TEMP; // see R17
          a_par = {{48{1'b0}}, (cmd == `C_TEMP) ? temp_i : // see R23
                   (cmd == `C_TEMPOFF) ? temp_off_i : temp_hys_i};
        end
        `C_SP_GET:  begin a_cmd = `A_SP; a_par = {32'h0, setpoint_o}; end
        `C_SP_MIN:  begin a_cmd = `A_SP; a_par = {32'h0, SP_MIN}; end
        `C_SP_MAX:  begin a_cmd = `A_SP; a_par = {32'h0, SP_MAX}; end
        `C_SP_EXT:  begin a_cmd = `A_SP; a_par = {32'h0, sp_ext_i}; end
        `C_LIM_GET: begin a_cmd = `A_SP; a_par = {32'h0, limit_o}; end
        `C_LIM_MIN: begin a_cmd = `A_SP; a_par = {32'h0, LIM_MIN}; end
        `C_LIM_MAX: begin a_cmd = `A_SP; a_par = {32'h0, LIM_MAX}; end
        `C_SP_SET, `C_SP_SETV: begin
          a_cmd = in_range(par, SP_MIN, SP_MAX) ? `A_SP : `A_ILLPAR; // see R22
          a_par = {32'h0, par[31:0]}; // see R18
        end
        `C_LIM_SET: begin
          a_cmd = in_range(par, LIM_MIN, LIM_MAX) ? `A_SP : `A_ILLPAR;
          a_par = {32'h0, par[31:0]};
        end
        `C_ST_RD: begin a_cmd = `A_ST; a_par = {32'h0, status_r}; end
        `C_ST_WR: begin // see R19
          a_cmd = `A_ST;
          a_par = {32'h0, par[31:0] & `ST_MASK};
        end
        `C_FLT_RD:  begin a_cmd = `A_FLT; a_par = {32'h0, fault_r}; end
        `C_REGS_RD: begin
          a_cmd = `A_REGS;
          a_par = {fault_r, status_r}; // see R21
        end
        `C_FLT_CLR: a_cmd = `A_FLTCLR;
        `C_STORE, `C_RECALL: a_cmd = `A_SETTINGS; // see R20
        `C_VCC: begin a_cmd = `A_VCC; a_par = {48'h0, vcc_i}; end
        `C_KP_MIN: begin a_cmd = `A_KP; a_par = {32'h0, K_MIN}; end
        `C_KP_MAX: begin a_cmd = `A_KP; a_par = {32'h0, K_MAX}; end
        `C_KP_GET: begin a_cmd = `A_KP; a_par = {32'h0, kp_o}; end
        `C_KP_SET: begin
          a_cmd = in_range(par, K_MIN, K_MAX) ? `A_KP : `A_ILLPAR; // see R6
          a_par = {32'h0, par[31:0]};
        end
        `C_KI_MIN: begin a_cmd = `A_KI; a_par = {32'h0, K_MIN}; end
        `C_KI_MAX: begin a_cmd = `A_KI; a_par = {32'h0, K_MAX}; end
        `C_KI_GET: begin a_cmd = `A_KI; a_par = {32'h0, ki_o}; end
        `C_KI_SET: begin
          a_cmd = in_range(par, K_MIN, K_MAX) ? `A_KI : `A_ILLPAR;
          a_par = {32'h0, par[31:0]};
        end
        default: a_cmd = `A_UNKNOWN_COMMAND_REPLY; // see R7
      endcase
      if (a_cmd == `A_ILLPAR) a_par = 64'h0; // see R6
    end
  end
  wire exec = (state_r == S_EX) && ck_ok && (a_cmd != `A_ILLPAR); // see R8
  wire toggle_done = en_low_seen_r && enable_i && !en_prev_r;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      ans_r         <= 96'h0;
      last_r        <= 96'h0;
      setpoint_o    <= `SP_RESET;
      limit_o       <= `LIM_RESET;
      kp_o          <= K_MIN;
      ki_o          <= K_MIN;
      status_r      <= `ST_RESET;
      fault_r       <= 32'h0;
      err_r         <= 1'b0;
      en_prev_r     <= 1'b0;
      en_low_seen_r <= 1'b0;
      store_o       <= 1'b0;
      recall_o      <= 1'b0;
      output_on_o   <= 1'b0;
      cmd_status_o  <= 2'b00;
    end else begin
      store_o   <= exec && (cmd == `C_STORE);
      recall_o  <= exec && (cmd == `C_RECALL);
      en_prev_r <= enable_i;
      if (state_r == S_EX) begin
        if (is_rep) begin
          ans_r <= last_r; // see R9
        end else begin
          ans_r  <= {a_cmd, a_par, 8'h00, // see R3
                     a_cmd[15:8] ^ a_cmd[7:0] ^ a_par[63:56] ^ a_par[55:48]
                     ^ a_par[47:40] ^ a_par[39:32] ^ a_par[31:24]
                     ^ a_par[23:16] ^ a_par[15:8] ^ a_par[7:0]}; // see R4
          last_r <= {a_cmd, a_par, 8'h00,
                     a_cmd[15:8] ^ a_cmd[7:0] ^ a_par[63:56] ^ a_par[55:48]
                     ^ a_par[47:40] ^ a_par[39:32] ^ a_par[31:24]
                     ^ a_par[23:16] ^ a_par[15:8] ^ a_par[7:0]};
        end
      end
      if (exec) begin
        case (cmd)
          `C_SP_SET, `C_SP_SETV: setpoint_o <= par[31:0];
          `C_LIM_SET: limit_o <= par[31:0];
          `C_KP_SET:  kp_o    <= par[31:0];
          `C_KI_SET:  ki_o    <= par[31:0];
          `C_ST_WR:   status_r <= par[31:0] & `ST_MASK;
          default:    status_r <= status_r;
        endcase
      end
      if (fault_event_i) begin
        err_r         <= 1'b1; // see R15
        en_low_seen_r <= 1'b0;
        fault_r       <= fault_r | fault_bits_i;
      end else begin
        if (err_r && !enable_i) begin
          en_low_seen_r <= 1'b1; // see R16
        end
        if (err_r && toggle_done) begin
          err_r         <= 1'b0; // see R16
          en_low_seen_r <= 1'b0;
          fault_r       <= 32'h0;
        end else if (exec && (cmd == `C_FLT_CLR)) begin
          fault_r <= 32'h0;
        end
      end
      output_on_o  <= !err_r && !fault_event_i && enable_i
                      && status_r[`ST_LON_BIT]; // see R15
      cmd_status_o <= {err_r, output_on_o}; // see R15
    end
  end
  // ==========================================================
  // Answer byte stream through the FIFO
  wire [7:0] push_byte = ans_r[95 - 8*tx_idx_r -: 8];
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (push_byte),
    .in_valid_i  (f_push),
    .in_ready_o  (f_ready),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (tx_ready_i)
  );
  always @* begin
    tx_data_o  = f_data;
    tx_valid_o = f_valid;
  end
endmodule // frame_cmd

// ---- bench/frame_cmd_asserts.sv ----
`timescale 1ns/100ps
module frame_cmd_asserts (
  input wire       mclk_i,
  input wire       resetn_i,
  input wire [7:0] tx_data_o,
  input wire       tx_valid_o,
  input wire       tx_ready_i,
  input wire       enable_i,
  input wire       fault_event_i,
  input wire       output_on_o,
  input wire [1:0] cmd_status_o,
  input wire       store_o,
  input wire       recall_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // Answer byte position and running XOR
  reg  [3:0] pos_r;
  reg  [7:0] acc_r;
  wire       take = tx_valid_o && tx_ready_i;
  always @(posedge mclk_i) begin
    if (!resetn_i || (take && pos_r == 4'hB)) begin
      pos_r <= 4'h0;
      acc_r <= 8'h00;
    end else if (take) begin
      pos_r <= pos_r + 4'h1;
      acc_r <= acc_r ^ tx_data_o;
    end
  end
  sequence en_steady;
    enable_i [*4];
  endsequence
  sequence err_two;
    cmd_status_o[1] ##1 cmd_status_o[1];
  endsequence
  // ==========================================
  // Properties
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("answer byte dropped");
  AST_TX_RSVD: assert property (take && pos_r == 4'hA |->
    tx_data_o == 8'h00) else $error("reserved byte not zero");
  AST_TX_CKSUM: assert property (take && pos_r == 4'hB |->
    tx_data_o == acc_r) else $error("answer checksum wrong");
  AST_ON_NEEDS_EN: assert property (output_on_o |->
    $past(enable_i)) else $error("output on without enable");
  AST_FAULT_OFF: assert property (fault_event_i |-> ##[1:3]
    (!output_on_o && cmd_status_o[1])) else $error("fault not shown");
  AST_ERR_HOLD: assert property (en_steady ##0 cmd_status_o[1] |=>
    cmd_status_o[1]) else $error("error cleared without toggle");
  AST_ERR_OUT_OFF: assert property (err_two |->
    !output_on_o) else $error("output on in error state");
  AST_STORE_PULSE: assert property (store_o |=>
    !store_o) else $error("store pulse too long");
  AST_RECALL_PULSE: assert property (recall_o |=>
    !recall_o) else $error("recall pulse too long");
endmodule // frame_cmd_asserts

// ---- bench/host_model.sv ----
`timescale 1ns/100ps
module host_model (
  input  wire       mclk_i,
  output reg  [7:0] rx_data_o,
  output reg        rx_valid_o,
  input  wire [7:0] tx_data_i,
  input  wire       tx_valid_i,
  output reg        tx_ready_o = 1'b1
);
  // ==========================================
  // Frame sender
  reg        slow;
  reg [95:0] last_f;
  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    slow       = 1'b0;
  end
  function [7:0] xsum(input [95:0] f);
    integer i;
    begin
      xsum = 8'h00;
      for (i = 0; i < 11; i = i + 1) begin
        xsum = xsum ^ f[95-8*i -: 8];
      end
    end
  endfunction
  task put(input [95:0] f, input integer n);
    integer i;
    begin
      last_f = f;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge mclk_i);
        rx_data_o  = f[95-8*i -: 8];
        rx_valid_o = 1'b1;
      end
      @(negedge mclk_i);
      rx_valid_o = 1'b0;
      rx_data_o  = ~rx_data_o;
    end
  endtask
  task send(input [15:0] c, input [63:0] p, input [7:0] rs, cx,
            input integer n);
    reg [95:0] f;
    begin
      f      = {c, p, rs, 8'h00};
      f[7:0] = xsum(f) ^ cx;
      put(f, n);
    end
  endtask
  // ==========================================
  // Answer receiver, stalls every other cycle when slow
  always @(negedge mclk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  task recv(output [95:0] f);
    integer i, t;
    reg     got;
    begin
      f = 'x;
      for (i = 0; i < 12; i = i + 1) begin
        t   = 0;
        got = 1'b0;
        while (!got && t < 100) begin
          @(posedge mclk_i);
          t   = t + 1;
          got = tx_valid_i && tx_ready_o;
        end
        if (got) f[95-8*i -: 8] = tx_data_i;
      end
      if (f[95:80] === 16'hFF11) put(last_f, 12);
    end
  endtask
endmodule // host_model

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`include "frame_cmd_map.vh"
module tb_top;
  localparam        TMO    = 20;
  localparam [63:0] DEV_ID = 64'h00000000000A5A5A; // Arbitrary value
  localparam [23:0] HW_VER = 24'h010203;
  localparam [23:0] FW_VER = 24'h020304;
  localparam [63:0] ANY    = {64{1'b1}};
  localparam        NR     = 28;
  reg          mclk_i, resetn_i, enable_i, fault_event_i;
  reg  [31:0]  fault_bits;
  wire [7:0]   rx_data, tx_data;
  wire         rx_valid, tx_valid, tx_ready, output_on, store, recall;
  wire [1:0]   cmd_status;
  wire [31:0]  setpoint, limit, kp;
  reg  [159:0] rows [0:NR-1];
  integer      n_errors, check_count, i, n_pulse;
  host_model host_model_inst (.mclk_i(mclk_i), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready));
  frame_cmd #(.TIMEOUT_CYC(TMO), .DEVICE_ID(DEV_ID), .HW_VERSION(HW_VER),
    .FW_VERSION(FW_VER)) frame_cmd_inst (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .enable_i(enable_i), .fault_event_i(fault_event_i),
    .fault_bits_i(fault_bits), .temp_i(16'h00FA), .temp_off_i(16'h0352),
    .temp_hys_i(16'h02EE), .vcc_i(16'h00F0), .sp_ext_i(32'h0000ABCD),
    .output_on_o(output_on), .cmd_status_o(cmd_status),
    .setpoint_o(setpoint), .limit_o(limit), .kp_o(kp), .ki_o(),
    .store_o(store), .recall_o(recall), .rx_overrun_o());
  // Store pulses weigh 1, recall pulses 2
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      n_pulse <= 0;
    end else begin
      n_pulse <= n_pulse + (store ? 1 : 0) + (recall ? 2 : 0);
    end
  end
  // ==========================================
  // Shared tasks
  task cmp(input [63:0] got, exp, input [8*16:1] what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: %0s", $time, what);
      end
    end
  endtask
  task xfer(input [15:0] c, input [63:0] p, input [7:0] rs, cx,
            input [15:0] ec, input [63:0] ep);
    reg [95:0] f;
    begin
      host_model_inst.send(c, p, rs, cx, 12);
      host_model_inst.recv(f);
      cmp(64'(f[95:80]), 64'(ec), "answer code");
      if (ep !== ANY) cmp(f[79:16], ep, "answer value");
      cmp(64'(f[7:0]), 64'(host_model_inst.xsum(f)), "checksum");
    end
  endtask
  task done(input [8*16:1] name);
    $display("test %0s done", name);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ==========================================
  // Clock, watchdog and tests
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (4000) @(posedge mclk_i);
    n_errors = n_errors + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    resetn_i = 1'b0;
    enable_i = 1'b1;
    fault_event_i = 1'b0;
    fault_bits = 32'h00000000;
    n_errors = 0;
    check_count = 0;
    rows[0]  = {`C_PING, 64'h0, `A_PING, 64'h0};
    rows[1]  = {`C_IDENT, 64'h0, `A_IDENT, DEV_ID};
    rows[2]  = {`C_HWVER, 64'h0, `A_HWVER, 40'h0, HW_VER};
    rows[3]  = {`C_FWVER, 64'h0, `A_FWVER, 40'h0, FW_VER};
    rows[4]  = {`C_SERIAL, 64'h0, `A_SERIAL, ANY};
    rows[5]  = {`C_NAME, 64'h0, `A_NAME, ANY};
    rows[6]  = {`C_TEMP, 64'h0, `A_TEMP, 64'hFA};
    rows[7]  = {`C_TEMPOFF, 64'h0, `A_TEMP, 64'h352};
    rows[8]  = {`C_TEMPHYS, 64'h0, `A_TEMP, 64'h2EE};
    rows[9]  = {`C_SP_GET, 64'h0, `A_SP, 64'(`SP_RESET)};
    rows[10] = {`C_SP_MIN, 64'h0, `A_SP, 64'h64};
    rows[11] = {`C_SP_MAX, 64'h0, `A_SP, 64'h7D0};
    rows[12] = {`C_SP_SET, 64'h7D1, `A_ILLPAR, 64'h0};
    rows[13] = {`C_SP_SET, 64'h5DC, `A_SP, 64'h5DC};
    rows[14] = {`C_SP_EXT, 64'h0, `A_SP, 64'hABCD};
    rows[15] = {`C_LIM_GET, 64'h0, `A_SP, 64'(`LIM_RESET)};
    rows[16] = {`C_LIM_SET, 64'h400, `A_SP, 64'h400};
    rows[17] = {`C_SP_SETV, 64'h100, `A_SP, 64'h100};
    rows[18] = {`C_KP_GET, 64'h0, `A_KP, 64'h1};
    rows[19] = {`C_KP_SET, 64'h20, `A_KP, 64'h20};
    rows[20] = {`C_KI_SET, 64'h0, `A_ILLPAR, 64'h0};
    rows[21] = {`C_KI_GET, 64'h0, `A_KI, 64'h1};
    rows[22] = {`C_ST_RD, 64'h0, `A_ST, 64'(`ST_RESET)};
    rows[23] = {`C_REGS_RD, 64'h0, `A_REGS, 32'h0, `ST_RESET};
    rows[24] = {`C_VCC, 64'h0, `A_VCC, 64'hF0};
    rows[25] = {`C_STORE, 64'h0, `A_SETTINGS, 64'h0};
    rows[26] = {`C_RECALL, 64'h0, `A_SETTINGS, 64'h0};
    rows[27] = {16'h0099, 64'h0, `A_UNKNOWN_COMMAND_REPLY, 64'h0};
    repeat (12) @(negedge mclk_i);
    cmp(64'(output_on), 64'h0, "reset output");
    cmp(64'(cmd_status), 64'h0, "reset status");
    cmp(64'(setpoint), 64'(`SP_RESET), "reset setpoint");
    cmp(64'(limit), 64'(`LIM_RESET), "reset limit");
    cmp(64'(kp), 64'h1, "reset gain");
    resetn_i = 1'b1;
    done("reset");
    for (i = 0; i < NR; i = i + 1) begin
      xfer(rows[i][159:144], rows[i][143:80], 8'h00, 8'h00,
           rows[i][79:64], rows[i][63:0]);
    end
    cmp(n_pulse, 64'd3, "store pulses");
    xfer(`C_ST_WR, 64'hFF, 8'h00, 8'h00, `A_ST, 64'(`ST_MASK));
    xfer(`C_SERIAL, 64'h100, 8'h00, 8'h00, `A_ILLPAR, 64'h0);
    done("table");
    xfer(`C_SP_SET, 64'h200, 8'h00, 8'h01, `A_RXERR, ANY);
    xfer(`C_SP_GET, 64'h0, 8'h00, 8'h00, `A_SP, 64'h100);
    xfer(`C_PING, 64'h0, 8'h01, 8'h00, `A_RXERR, ANY);
    done("checksum");
    host_model_inst.send(`C_SP_SET, 64'h300, 8'h00, 8'h00, 5);
    repeat (TMO + 5) @(negedge mclk_i);
    xfer(`C_SP_GET, 64'h0, 8'h00, 8'h00, `A_SP, 64'h100);
    done("timeout");
    xfer(`A_REPEAT, 64'h0, 8'h00, 8'h00, `A_SP, 64'h100);
    host_model_inst.slow = 1'b1;
    xfer(`C_KI_SET, 64'h30, 8'h00, 8'h00, `A_KI, 64'h30);
    host_model_inst.slow = 1'b0;
    done("repeat stall");
    cmp(64'(cmd_status), 64'h1, "normal status");
    @(negedge mclk_i);
    fault_bits = 32'h00000004;
    fault_event_i = 1'b1;
    @(negedge mclk_i);
    fault_event_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    cmp(64'(output_on), 64'h0, "fault output");
    cmp(64'(cmd_status), 64'h2, "fault status");
    xfer(`C_FLT_RD, 64'h0, 8'h00, 8'h00, `A_FLT, 64'h4);
    xfer(`C_FLT_CLR, 64'h0, 8'h00, 8'h00, `A_FLTCLR, 64'h0);
    cmp(64'(cmd_status), 64'h2, "error kept");
    enable_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    enable_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    cmp(64'(output_on), 64'h1, "toggle output");
    cmp(64'(cmd_status), 64'h1, "toggle status");
    done("error");
    resetn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    cmp(64'(setpoint), 64'(`SP_RESET), "reset again");
    cmp(64'(cmd_status), 64'h0, "reset status 2");
    resetn_i = 1'b1;
    xfer(`C_SP_GET, 64'h0, 8'h00, 8'h00, `A_SP, 64'(`SP_RESET));
    done("reset again");
    tally_and_finish;
  end
endmodule // tb_top
bind frame_cmd frame_cmd_asserts frame_cmd_asserts_inst (.mclk_i(mclk_i),
  .resetn_i(resetn_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .enable_i(enable_i),
  .fault_event_i(fault_event_i), .output_on_o(output_on_o),
  .cmd_status_o(cmd_status_o), .store_o(store_o), .recall_o(recall_o));
